/* File: ppb_pkg.sv */
// package: register map, field positions, reset values and carriers of the parallel slave port buffers
package ppb_pkg;

  localparam int unsigned PPB_SLOTS = 4;

  // register base offsets (byte addresses); aliases sit at +0x4, +0x8, +0xC
  localparam logic [15:0] PPB_OFF_CONTROL    = 16'h7000;
  localparam logic [15:0] PPB_OFF_MODE       = 16'h7010;
  localparam logic [15:0] PPB_OFF_ADDRESS    = 16'h7020;
  localparam logic [15:0] PPB_OFF_DATA_OUT   = 16'h7030;
  localparam logic [15:0] PPB_OFF_DATA_IN    = 16'h7040;
  localparam logic [15:0] PPB_OFF_PIN_ENABLE = 16'h7050;
  localparam logic [15:0] PPB_OFF_STATUS     = 16'h7060;
  localparam logic [15:0] PPB_OFF_IRQ_STATUS = 16'h7070;
  localparam logic [15:0] PPB_OFF_IRQ_MASK   = 16'h7080;

  // status register fields
  localparam int unsigned PPB_BIT_IN_ALL_FULL   = 15;
  localparam int unsigned PPB_BIT_IN_OVERFLOW   = 14;
  localparam int unsigned PPB_LSB_IN_SLOT       = 8;
  localparam int unsigned PPB_BIT_OUT_ALL_EMPTY = 7;
  localparam int unsigned PPB_BIT_OUT_UNDERFLOW = 6;
  localparam int unsigned PPB_LSB_OUT_SLOT      = 0;
  localparam logic [15:0] PPB_STATUS_RESET      = 16'h008F;

  // control register
  localparam int unsigned PPB_BIT_CONTROL_ON = 15;

  // interrupt status and mask fields
  localparam int unsigned PPB_IRQ_W         = 4;
  localparam int unsigned PPB_IRQ_IN_BYTE   = 0;
  localparam int unsigned PPB_IRQ_OUT_TAKEN = 1;
  localparam int unsigned PPB_IRQ_OVERFLOW  = 2;
  localparam int unsigned PPB_IRQ_UNDERFLOW = 3;

  localparam logic [15:0] PPB_REG16_RESET = 16'h0000;
  localparam logic [31:0] PPB_WORD_ZERO   = 32'h0000_0000;

  typedef enum logic [1:0] {
    PPB_ALIAS_WRITE = 2'b00,
    PPB_ALIAS_CLEAR = 2'b01,
    PPB_ALIAS_SET   = 2'b10,
    PPB_ALIAS_INV   = 2'b11
  } ppb_alias_e;

  typedef enum logic [0:0] {
    PPB_ST_IDLE   = 1'b0,
    PPB_ST_ANSWER = 1'b1
  } ppb_apb_state_e;

  // one access of the external master on the parallel port
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [1:0] slot;
    logic [7:0] data;
  } ppb_ext_req_s;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [15:0] paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
  } ppb_apb_req_s;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } ppb_apb_rsp_s;

endpackage

/* File: ppb_slot.sv */
// one byte buffer slot with its occupied flag
`timescale 1ns/1ps
module ppb_slot (
  input  wire logic       core_clk_i,
  input  wire logic       resetn_i,
  input  wire logic       load_i,
  input  wire logic [7:0] load_data_i,
  input  wire logic       take_i,
  output logic      [7:0] data_o,
  output logic            full_o
);
  logic [7:0] data_q;
  logic [7:0] data_d;
  logic       full_q;
  logic       full_d;

  // a load in the same cycle as a take wins, so no byte is lost
  always_comb begin
    data_d = data_q;
    full_d = full_q;
    if (take_i) begin
      full_d = 1'b0;
    end
    if (load_i) begin
      data_d = load_data_i;
      full_d = 1'b1;
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      data_q <= 8'h00;
      full_q <= 1'b0;
    end else begin
      data_q <= data_d;
      full_q <= full_d;
    end
  end

  assign data_o = data_q;
  assign full_o = full_q;
endmodule

/* File: ppb_top.sv */
// parallel slave port buffers: apb register file, four input and four output byte slots
// Operation
// - input all-full flag set only when every slot full
// - write to full input slot sets sticky overflow
// - per-slot input full flags, cleared by software read
// - output all-empty flag set only when all empty
// - read of empty output slot sets sticky underflow
// - per-slot output empty flags, cleared by software write
// - status register resets to 008F
// - clear, set, invert aliases at +4, +8, +C, except irq status: every alias clears bits written one
// - unimplemented bits ignore writes, read zero
`timescale 1ns/1ps
module ppb_top (
  input  wire logic                 core_clk_i,
  input  wire logic                 resetn_i,
  input  wire ppb_pkg::ppb_apb_req_s apb_req_i,
  output ppb_pkg::ppb_apb_rsp_s      apb_rsp_o,
  input  wire ppb_pkg::ppb_ext_req_s ext_req_i,
  output logic [7:0]                 ext_rdata_o,
  output logic                       irq_o
);
  import ppb_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [31:0] ppb_alias(input logic [31:0] old, input logic [31:0] wdata,
                                            input ppb_alias_e kind);
    logic [31:0] res;
    res = wdata;
    case (kind)
      PPB_ALIAS_WRITE: res = wdata;
      PPB_ALIAS_CLEAR: res = old & ~wdata;
      PPB_ALIAS_SET:   res = old | wdata;
      PPB_ALIAS_INV:   res = old ^ wdata;
      default:         res = wdata;
    endcase
    return res;
  endfunction

  function automatic logic [31:0] ppb_lanes(input logic [31:0] old, input logic [31:0] upd,
                                            input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = upd[8*i +: 8];
      end
    end
    return res;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // state

  ppb_apb_state_e state_q;
  ppb_apb_state_e state_d;
  ppb_apb_rsp_s   rsp_q;
  ppb_apb_rsp_s   rsp_d;
  logic [15:0]    control_q, control_d;
  logic [15:0]    mode_q, mode_d;
  logic [15:0]    address_q, address_d;
  logic [15:0]    pin_en_q, pin_en_d;
  logic           in_ovf_q, in_ovf_d;
  logic           out_unf_q, out_unf_d;
  logic [3:0]     irq_stat_q, irq_stat_d;
  logic [3:0]     irq_mask_q, irq_mask_d;
  logic           irq_q, irq_d;
  logic [7:0]     ext_rdata_q, ext_rdata_d;

  logic [3:0]  in_full;
  logic [3:0]  out_full;
  logic [3:0]  in_load;
  logic [3:0]  in_take;
  logic [3:0]  out_load;
  logic [3:0]  out_take;
  logic [31:0] in_word;
  logic [31:0] out_word;
  logic [31:0] out_new;
  logic [15:0] status_word;
  logic        in_all_full;
  logic        out_all_empty;

  //////////////////////////////////////////////////////////////////////////////
  // bus decode

  logic        access;
  logic        commit;
  logic        wr_commit;
  logic        rd_commit;
  logic [15:0] reg_base;
  ppb_alias_e  alias_kind;
  logic        mapped;

  assign access     = apb_req_i.psel & apb_req_i.penable;
  assign commit     = access & (state_q == PPB_ST_ANSWER);
  assign wr_commit  = commit & mapped & apb_req_i.pwrite;
  assign rd_commit  = commit & mapped & ~apb_req_i.pwrite;
  assign reg_base   = {apb_req_i.paddr[15:4], 4'h0};
  assign alias_kind = ppb_alias_e'(apb_req_i.paddr[3:2]);
  assign mapped     = (apb_req_i.paddr[1:0] == 2'b00) && (reg_base >= PPB_OFF_CONTROL)
                      && (reg_base <= PPB_OFF_IRQ_MASK);

  //////////////////////////////////////////////////////////////////////////////
  // byte slots

  logic ext_on;
  logic ext_wr;
  logic ext_rd;
  logic ovf_event;
  logic unf_event;

  assign ext_on    = control_q[PPB_BIT_CONTROL_ON];
  assign ext_wr    = ext_on & ext_req_i.wr;
  assign ext_rd    = ext_on & ext_req_i.rd;
  assign ovf_event = ext_wr & in_full[ext_req_i.slot];
  assign unf_event = ext_rd & ~out_full[ext_req_i.slot];
  assign out_new   = ppb_alias(out_word, apb_req_i.pwdata, alias_kind);

  for (genvar g = 0; g < PPB_SLOTS; g++) begin : g_slot
    // a write to a full input slot keeps the old byte
    assign in_load[g]  = ext_wr & (ext_req_i.slot == 2'(g)) & ~in_full[g];
    assign in_take[g]  = rd_commit & (reg_base == PPB_OFF_DATA_IN);
    assign out_load[g] = wr_commit & (reg_base == PPB_OFF_DATA_OUT) & apb_req_i.pstrb[g];
    assign out_take[g] = ext_rd & (ext_req_i.slot == 2'(g)) & out_full[g];

    ppb_slot u_in_slot (
      .core_clk_i  (core_clk_i),
      .resetn_i    (resetn_i),
      .load_i      (in_load[g]),
      .load_data_i (ext_req_i.data),
      .take_i      (in_take[g]),
      .data_o      (in_word[8*g +: 8]),
      .full_o      (in_full[g])
    );

    ppb_slot u_out_slot (
      .core_clk_i  (core_clk_i),
      .resetn_i    (resetn_i),
      .load_i      (out_load[g]),
      .load_data_i (out_new[8*g +: 8]),
      .take_i      (out_take[g]),
      .data_o      (out_word[8*g +: 8]),
      .full_o      (out_full[g])
    );
  end

  assign in_all_full   = &in_full;
  assign out_all_empty = ~|out_full;
  assign status_word = {in_all_full, in_ovf_q, 2'b00, in_full, out_all_empty, out_unf_q, 2'b00, ~out_full};

  //////////////////////////////////////////////////////////////////////////////
  // register next values

  logic [31:0] upd;
  logic [31:0] cur;

  always_comb begin
    control_d   = control_q;
    mode_d      = mode_q;
    address_d   = address_q;
    pin_en_d    = pin_en_q;
    irq_mask_d  = irq_mask_q;
    irq_stat_d  = irq_stat_q;
    in_ovf_d    = in_ovf_q;
    out_unf_d   = out_unf_q;
    cur         = PPB_WORD_ZERO;
    upd         = PPB_WORD_ZERO;
    case (reg_base)
      PPB_OFF_CONTROL:    cur = {16'h0000, control_q};
      PPB_OFF_MODE:       cur = {16'h0000, mode_q};
      PPB_OFF_ADDRESS:    cur = {16'h0000, address_q};
      PPB_OFF_PIN_ENABLE: cur = {16'h0000, pin_en_q};
      PPB_OFF_STATUS:     cur = {16'h0000, status_word};
      PPB_OFF_IRQ_MASK:   cur = {28'h0000000, irq_mask_q};
      default:            cur = PPB_WORD_ZERO;
    endcase
    upd = ppb_lanes(cur, ppb_alias(cur, apb_req_i.pwdata, alias_kind), apb_req_i.pstrb);
    if (wr_commit) begin
      case (reg_base)
        PPB_OFF_CONTROL:    control_d  = upd[15:0];
        PPB_OFF_MODE:       mode_d     = upd[15:0];
        PPB_OFF_ADDRESS:    address_d  = upd[15:0];
        PPB_OFF_PIN_ENABLE: pin_en_d   = upd[15:0];
        PPB_OFF_IRQ_MASK:   irq_mask_d = upd[3:0];
        // software may only drop the error flags, never raise them
        PPB_OFF_STATUS: begin
          in_ovf_d  = in_ovf_q & upd[PPB_BIT_IN_OVERFLOW];
          out_unf_d = out_unf_q & upd[PPB_BIT_OUT_UNDERFLOW];
        end
        // any alias of the interrupt status clears the bits written with one
        PPB_OFF_IRQ_STATUS: irq_stat_d = irq_stat_q & ~(apb_req_i.pwdata[3:0] & {4{apb_req_i.pstrb[0]}});
        default:            control_d  = control_q;
      endcase
    end
    // hardware set wins over a clear in the same cycle
    in_ovf_d  = in_ovf_d | ovf_event;
    out_unf_d = out_unf_d | unf_event;
    irq_stat_d[PPB_IRQ_IN_BYTE]   = irq_stat_d[PPB_IRQ_IN_BYTE] | (|in_load);
    irq_stat_d[PPB_IRQ_OUT_TAKEN] = irq_stat_d[PPB_IRQ_OUT_TAKEN] | (|out_take);
    irq_stat_d[PPB_IRQ_OVERFLOW]  = irq_stat_d[PPB_IRQ_OVERFLOW] | ovf_event;
    irq_stat_d[PPB_IRQ_UNDERFLOW] = irq_stat_d[PPB_IRQ_UNDERFLOW] | unf_event;
    irq_d = |(irq_stat_d & irq_mask_d);
  end

  always_comb begin
    ext_rdata_d = ext_rdata_q;
    if (ext_rd) begin
      ext_rdata_d = out_word[8*ext_req_i.slot +: 8];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // apb answer: one wait state, read data captured in the first access cycle

  always_comb begin
    state_d = state_q;
    rsp_d   = '0;
    case (state_q)
      PPB_ST_IDLE: begin
        if (access) begin
          state_d       = PPB_ST_ANSWER;
          rsp_d.pready  = 1'b1;
          rsp_d.pslverr = ~mapped;
          if (mapped && !apb_req_i.pwrite) begin
            case (reg_base)
              PPB_OFF_DATA_OUT:   rsp_d.prdata = out_word;
              PPB_OFF_DATA_IN:    rsp_d.prdata = in_word;
              PPB_OFF_IRQ_STATUS: rsp_d.prdata = {28'h0000000, irq_stat_q};
              default:            rsp_d.prdata = cur;
            endcase
          end
        end
      end
      PPB_ST_ANSWER: state_d = PPB_ST_IDLE;
      default:       state_d = PPB_ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q     <= PPB_ST_IDLE;
      rsp_q       <= '0;
      control_q   <= PPB_REG16_RESET;
      mode_q      <= PPB_REG16_RESET;
      address_q   <= PPB_REG16_RESET;
      pin_en_q    <= PPB_REG16_RESET;
      in_ovf_q    <= 1'b0;
      out_unf_q   <= 1'b0;
      irq_stat_q  <= 4'h0;
      irq_mask_q  <= 4'h0;
      irq_q       <= 1'b0;
      ext_rdata_q <= 8'h00;
    end else begin
      state_q     <= state_d;
      rsp_q       <= rsp_d;
      control_q   <= control_d;
      mode_q      <= mode_d;
      address_q   <= address_d;
      pin_en_q    <= pin_en_d;
      in_ovf_q    <= in_ovf_d;
      out_unf_q   <= out_unf_d;
      irq_stat_q  <= irq_stat_d;
      irq_mask_q  <= irq_mask_d;
      irq_q       <= irq_d;
      ext_rdata_q <= ext_rdata_d;
    end
  end

  assign apb_rsp_o   = rsp_q;
  assign ext_rdata_o = ext_rdata_q;
  assign irq_o       = irq_q;

  //////////////////////////////////////////////////////////////////////////////
  // checks

  logic status_rd_setup;
  assign status_rd_setup = access & (state_q == PPB_ST_IDLE) & ~apb_req_i.pwrite
                           & (apb_req_i.paddr == PPB_OFF_STATUS);

  a_in_all_full: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    status_rd_setup |=> rsp_q.prdata[15] == (&$past(in_full)))
    else $error("input all-full flag wrong");

  a_ovf_set: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    ovf_event |=> in_ovf_q && irq_stat_q[2])
    else $error("overflow not flagged");

  a_in_slot_clear: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    (rd_commit && reg_base == PPB_OFF_DATA_IN) |=> (in_full & ~$past(in_load)) == 4'h0)
    else $error("input slot flag not cleared by read");

  a_out_all_empty: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    status_rd_setup |=> rsp_q.prdata[7] == ~|$past(out_full))
    else $error("output all-empty flag wrong");

  a_unf_sticky: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    unf_event ##1 !wr_commit [*3] |-> out_unf_q)
    else $error("underflow flag lost");

  a_out_slot_load: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    (wr_commit && reg_base == PPB_OFF_DATA_OUT && apb_req_i.pstrb[0]) |=> !status_word[0])
    else $error("output slot still empty after write");

  a_status_reset: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    $rose(resetn_i) |-> status_word == PPB_STATUS_RESET)
    else $error("status reset value wrong");

  a_mask_set_alias: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    (wr_commit && apb_req_i.paddr == (PPB_OFF_IRQ_MASK + 16'h0008) && apb_req_i.pstrb[0])
    |=> irq_mask_q == ($past(irq_mask_q) | $past(apb_req_i.pwdata[3:0])))
    else $error("set alias did not or into mask");

  a_upper_zero: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    status_rd_setup ##1 rsp_q.pready |-> rsp_q.prdata[31:16] == 16'h0000)
    else $error("unimplemented status bits read nonzero");

  a_w1_no_effect: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    (wr_commit && apb_req_i.paddr == PPB_OFF_STATUS && apb_req_i.pstrb[1]
     && apb_req_i.pwdata[14] && in_ovf_q) |=> in_ovf_q)
    else $error("writing one cleared overflow");

endmodule

/* File: ppb_ext_master.sv */
// external master model: byte writes and reads on the parallel port side
`timescale 1ns/1ps
module ppb_ext_master (
  input  wire logic [0:0]        core_clk_i,
  input  wire logic [7:0]        ext_rdata_i,
  output ppb_pkg::ppb_ext_req_s  ext_req_o
);
  import ppb_pkg::*;

  initial ext_req_o = '0;

  ////////////////////////////////////////////////////////////////////////////////
  // one byte access after gap idle cycles; on release wr and rd drop to zero, slot and data lines show inverted values
  task automatic access(input logic wr, input logic [1:0] slot, input logic [7:0] data,
                        input int gap, output logic [7:0] rdata);
    repeat (gap) @(posedge core_clk_i);
    @(posedge core_clk_i);
    ext_req_o.wr   <= wr;
    ext_req_o.rd   <= !wr;
    ext_req_o.slot <= slot;
    ext_req_o.data <= data;
    @(posedge core_clk_i);
    ext_req_o.wr   <= 1'b0;
    ext_req_o.rd   <= 1'b0;
    ext_req_o.slot <= ~slot;
    ext_req_o.data <= ~data;
    #1 rdata = ext_rdata_i;
  endtask
endmodule

/* File: tb_parallel_slave_port_buffers.sv */
// testbench of the parallel slave port buffers
`timescale 1ns/1ps
module tb_parallel_slave_port_buffers;
  import ppb_pkg::*;

  logic         core_clk_i;
  logic         resetn_i;
  ppb_apb_req_s apb_req;
  ppb_apb_rsp_s apb_rsp;
  ppb_ext_req_s ext_req;
  logic [7:0]   ext_rdata;
  logic         irq;
  int           error_cnt;
  int           n_tests;
  logic [31:0]  rd;
  logic         err;
  logic [7:0]   b;

  ppb_top ppb_top_i (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .apb_req_i(apb_req), .apb_rsp_o(apb_rsp),
                     .ext_req_i(ext_req), .ext_rdata_o(ext_rdata), .irq_o(irq));
  ppb_ext_master ppb_ext_master_i (.core_clk_i(core_clk_i), .ext_rdata_i(ext_rdata), .ext_req_o(ext_req));

  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [15:0] addr, input logic [31:0] wdata,
                     output logic [31:0] rdata, output logic slverr);
    @(posedge core_clk_i);
    apb_req.psel    <= 1'b1;
    apb_req.penable <= 1'b0;
    apb_req.pwrite  <= wr;
    apb_req.paddr   <= addr;
    apb_req.pwdata  <= wdata;
    @(posedge core_clk_i);
    apb_req.penable <= 1'b1;
    // pready ends this wait; only the watchdog ends it if pready never comes
    do begin
      @(posedge core_clk_i);
    end while (apb_rsp.pready !== 1'b1);
    rdata = apb_rsp.prdata;
    slverr = apb_rsp.pslverr;
    apb_req.psel    <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask

  task automatic wreg(input logic [15:0] addr, input logic [31:0] data);
    apb(1'b1, addr, data, rd, err);
  endtask

  task automatic rchk(input logic [15:0] addr, input logic [31:0] exp);
    apb(1'b0, addr, 32'h0000_0000, rd, err);
    chk(rd, exp);
  endtask

  // irq follows its cause on the same edge as the register update
  task automatic irq_chk(input logic exp);
    repeat (2) @(posedge core_clk_i);
    #1 chk({31'h0, irq}, {31'h0, exp});
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rchk(PPB_OFF_STATUS, 32'h0000_008F);
    rchk(PPB_OFF_CONTROL, 32'h0000_0000);
    apb(1'b0, 16'h7090, 32'h0000_0000, rd, err);
    chk({31'h0, err}, 32'h0000_0001);
    wreg(PPB_OFF_STATUS, 32'hFFFF_FFFF);
    rchk(PPB_OFF_STATUS, 32'h0000_008F);
    wreg(PPB_OFF_CONTROL, 32'hFFFF_FFFF);
    rchk(PPB_OFF_CONTROL, 32'h0000_FFFF);
    wreg(PPB_OFF_CONTROL, 32'h0000_8000);
  endtask

  task automatic t_input;
    for (int i = 0; i < 4; i++) begin
      ppb_ext_master_i.access(1'b1, 2'(i), 8'hA0 + 8'(i), i, b);
      rchk(PPB_OFF_STATUS, 32'h8F | ((32'h1 << (i + 1)) - 1) << 8 | (i == 3 ? 32'h8000 : 32'h0));
    end
    ppb_ext_master_i.access(1'b1, 2'd1, 8'h55, 0, b);
    rchk(PPB_OFF_STATUS, 32'h0000_CF8F);
    rchk(PPB_OFF_DATA_IN, 32'hA3A2_A1A0);
    rchk(PPB_OFF_STATUS, 32'h0000_408F);
    wreg(PPB_OFF_STATUS, 32'h0000_4040);
    rchk(PPB_OFF_STATUS, 32'h0000_408F);
    wreg(PPB_OFF_STATUS + 16'h4, 32'h0000_4000);
    rchk(PPB_OFF_STATUS, 32'h0000_008F);
  endtask

  task automatic t_output;
    wreg(PPB_OFF_DATA_OUT, 32'h4433_2211);
    rchk(PPB_OFF_STATUS, 32'h0000_0000);
    for (int i = 0; i < 4; i++) begin
      ppb_ext_master_i.access(1'b0, 2'(i), 8'h00, 0, b);
      chk({24'h0, b}, 32'h11 * (i + 1));
      rchk(PPB_OFF_STATUS, ((32'h1 << (i + 1)) - 1) | (i == 3 ? 32'h80 : 32'h0));
    end
    ppb_ext_master_i.access(1'b0, 2'd0, 8'h00, 2, b);
    chk({24'h0, b}, 32'h0000_0011);
    rchk(PPB_OFF_STATUS, 32'h0000_00CF);
    wreg(PPB_OFF_STATUS + 16'h8, 32'h0000_0040);
    rchk(PPB_OFF_STATUS, 32'h0000_00CF);
    wreg(PPB_OFF_STATUS + 16'h4, 32'h0000_0040);
    rchk(PPB_OFF_STATUS, 32'h0000_008F);
  endtask

  task automatic t_alias;
    wreg(PPB_OFF_MODE, 32'h0000_00F0);
    wreg(PPB_OFF_MODE + 16'h8, 32'h0000_000F);
    rchk(PPB_OFF_MODE, 32'h0000_00FF);
    wreg(PPB_OFF_MODE + 16'h4, 32'h0000_00F0);
    rchk(PPB_OFF_MODE, 32'h0000_000F);
    wreg(PPB_OFF_MODE + 16'hC, 32'h0000_0101);
    rchk(PPB_OFF_MODE, 32'h0000_010E);
  endtask

  task automatic t_irq;
    wreg(PPB_OFF_IRQ_STATUS, 32'h0000_000F);
    wreg(PPB_OFF_IRQ_MASK, 32'h0000_0001);
    irq_chk(1'b0);
    ppb_ext_master_i.access(1'b1, 2'd0, 8'h5A, 1, b);
    irq_chk(1'b1);
    rchk(PPB_OFF_IRQ_STATUS, 32'h0000_0001);
    wreg(PPB_OFF_IRQ_MASK, 32'h0000_0000);
    irq_chk(1'b0);
    wreg(PPB_OFF_IRQ_MASK, 32'h0000_0001);
    irq_chk(1'b1);
    wreg(PPB_OFF_IRQ_STATUS, 32'h0000_0001);
    irq_chk(1'b0);
    rchk(PPB_OFF_STATUS, 32'h0000_018F);
    wreg(PPB_OFF_IRQ_MASK + 16'h8, 32'h0000_0002);
    rchk(PPB_OFF_IRQ_MASK, 32'h0000_0003);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic conclude;
    $display("comparisons %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    error_cnt = 0;
    n_tests   = 0;
    resetn_i  = 1'b0;
    apb_req   = '0;
    apb_req.pstrb = 4'hF;
    repeat (20) @(posedge core_clk_i);
    resetn_i <= 1'b1;
    t_reset();
    t_input();
    t_output();
    t_alias();
    t_irq();
    conclude();
  end

  // the tests need about 250 cycles; 20,000 cycles means a hang
  initial begin
    #200000;
    error_cnt++;
    conclude();
  end
endmodule
